// *** iwr_pkg.sv ***
// package of shared constants and types for the wait-release control
package iwr_pkg;
  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int IWR_DATA_W = 8;
  localparam logic IWR_WAIT_RST = 1'b0;
  localparam logic IWR_TOG_RST = 1'b0;
  localparam logic [IWR_DATA_W-1:0] IWR_DATA_RST = 8'h00;
  localparam int IWR_SYNC_STAGES = 2;
  // ---------------------------------------------------------------
  // kinds of release action, as passed to the link side
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    IWR_K_NONE,
    IWR_K_TX,
    IWR_K_REL,
    IWR_K_START,
    IWR_K_STOP,
    IWR_K_EXIT,
    IWR_K_DISABLE
  } iwr_kind_e;
endpackage : iwr_pkg

// *** iwr_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/1ns
module iwr_sync (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst_n,
  // level from the other domain and its safe copy
  input wire logic din,
  output logic dout
);
  import iwr_pkg::*;
  logic meta_q;
  // ---------------------------------------------------------------
  // first stage feeds only the second stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : iwr_sync

// *** iwr_wait_release.sv ***
// wait-release control of the serial bus interface, two clock domains
// Function
// (RULE1) shift register write releases, sends byte
// (RULE2) wait-release bit ends the wait
// (RULE3) master start request releases, makes start
// (RULE4) master stop request releases, makes stop
// (RULE5) accepted release resumes the stalled transfer
// (RULE6) software releases receive with wait-release bit
// (RULE7) one release action per wait only
// (RULE8) no shift write after wait-release
// (RULE9) clearing interface enable releases the wait
// (RULE10) communication-exit bit withdraws and releases
// (RULE11) address-match wakeup blocks every release
// (RULE12) wait holds serial clock line low
`timescale 1ns/1ns
module iwr_wait_release (
  // system clock domain
  input wire logic mclk,
  input wire logic arst_n,
  // software control strobes, one-cycle pulses on mclk
  input wire logic shift_wr,
  input wire logic [iwr_pkg::IWR_DATA_W-1:0] serial_shift_reg,
  input wire logic wait_release_bit,
  input wire logic start_request_bit,
  input wire logic stop_request_bit,
  input wire logic comm_exit_bit,
  // software control levels
  input wire logic iface_enable_bit,
  input wire logic address_match_wakeup,
  input wire logic master_mode,
  // status toward software
  output logic wait_active,
  output logic release_accepted,
  // link clock domain
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic byte_wait_req,
  // link side results
  output logic resume_pulse,
  output iwr_pkg::iwr_kind_e resume_kind,
  output logic [iwr_pkg::IWR_DATA_W-1:0] resume_data,
  // serial clock line drive, open drain
  output logic scl_o,
  output logic scl_oe
);
  import iwr_pkg::*;

  // ---------------------------------------------------------------
  // system domain: pick and accept one release action
  // ---------------------------------------------------------------
  logic wait_seen;
  logic pending_q, pending_d;
  logic rel_tog_q;
  logic en_q;
  iwr_kind_e kind_q;
  logic [IWR_DATA_W-1:0] data_q;
  // link-domain wait flag, read here only through the synchroniser
  logic link_wait_q;
  wire dis_ev = en_q & ~iface_enable_bit;
  wire start_ok = master_mode & start_request_bit;
  wire stop_ok = master_mode & stop_request_bit;
  wire any_act = dis_ev | comm_exit_bit | stop_ok | start_ok | shift_wr | wait_release_bit;
  // wakeup gates all actions; pending blocks a second one for this wait
  wire accept = wait_seen & ~pending_q & ~address_match_wakeup & any_act; // RULE11 RULE7
  // priority: abort paths first, then bus conditions, then data
  wire iwr_kind_e act_kind = dis_ev ? IWR_K_DISABLE :            // RULE9
                             comm_exit_bit ? IWR_K_EXIT :        // RULE10
                             stop_ok ? IWR_K_STOP :              // RULE4
                             start_ok ? IWR_K_START :            // RULE3
                             shift_wr ? IWR_K_TX :               // RULE1
                             IWR_K_REL;                          // RULE2
  assign pending_d = accept ? 1'b1 : (wait_seen ? pending_q : 1'b0);
  assign release_accepted = accept;
  assign wait_active = wait_seen;

  iwr_sync u_sync_wait (
    .clk(mclk),
    .rst_n(arst_n),
    .din(link_wait_q),
    .dout(wait_seen)
  );

  // kind and byte are held stable until the link has seen the toggle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pending_q <= 1'b0;
      rel_tog_q <= IWR_TOG_RST;
      en_q <= 1'b0;
      kind_q <= IWR_K_NONE;
      data_q <= IWR_DATA_RST;
    end else begin
      pending_q <= pending_d;
      en_q <= iface_enable_bit;
      if (accept) begin
        rel_tog_q <= ~rel_tog_q;
        kind_q <= act_kind;
        data_q <= serial_shift_reg; // RULE1
      end
    end
  end

  // ---------------------------------------------------------------
  // link domain: hold the wait, resume on the release toggle
  // ---------------------------------------------------------------
  logic tog_seen;
  logic tog_last_q;
  wire rel_ev = tog_seen ^ tog_last_q;

  iwr_sync u_sync_tog (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .din(rel_tog_q),
    .dout(tog_seen)
  );

  // a new wait request wins over a release in the same cycle
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_wait_q <= IWR_WAIT_RST;
      tog_last_q <= IWR_TOG_RST;
      resume_pulse <= 1'b0;
      resume_kind <= IWR_K_NONE;
      resume_data <= IWR_DATA_RST;
    end else begin
      tog_last_q <= tog_seen;
      resume_pulse <= rel_ev & link_wait_q; // RULE5
      if (byte_wait_req) begin
        link_wait_q <= 1'b1;
      end else if (rel_ev) begin
        link_wait_q <= 1'b0; // RULE5
      end
      if (rel_ev) begin
        resume_kind <= kind_q;
        resume_data <= data_q;
      end
    end
  end

  // clock line pulled low only while stalled
  assign scl_o = 1'b0;
  assign scl_oe = link_wait_q; // RULE12

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wire only_tx = shift_wr & ~dis_ev & ~comm_exit_bit & ~stop_ok & ~start_ok;
  property p_tx;
    @(posedge mclk) disable iff (!arst_n)
    (accept && only_tx) |=> (kind_q == IWR_K_TX && data_q == $past(serial_shift_reg));
  endproperty
  a_tx: assert property (p_tx) else $error("shift write did not release as tx"); // RULE1
  property p_rel;
    @(posedge mclk) disable iff (!arst_n)
    (wait_seen && !pending_q && !address_match_wakeup && wait_release_bit && !only_tx
     && !dis_ev && !comm_exit_bit && !stop_ok && !start_ok && !shift_wr)
    |=> (kind_q == IWR_K_REL && rel_tog_q != $past(rel_tog_q));
  endproperty
  a_rel: assert property (p_rel) else $error("wait release bit ignored"); // RULE2
  property p_start_slave;
    @(posedge mclk) disable iff (!arst_n)
    (!master_mode && start_request_bit && !stop_request_bit && !shift_wr
     && !wait_release_bit && !comm_exit_bit && !dis_ev) |-> !accept;
  endproperty
  a_start_slave: assert property (p_start_slave) else $error("slave start released"); // RULE3
  property p_stop;
    @(posedge mclk) disable iff (!arst_n)
    (accept && stop_ok && !dis_ev && !comm_exit_bit) |=> kind_q == IWR_K_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop request not taken"); // RULE4
  property p_resume;
    @(posedge link_clk) disable iff (!link_rst_n)
    (link_wait_q && rel_ev && !byte_wait_req) |=> (!link_wait_q && resume_pulse);
  endproperty
  a_resume: assert property (p_resume) else $error("release did not resume"); // RULE5
  property p_disable;
    @(posedge mclk) disable iff (!arst_n)
    (wait_seen && !pending_q && !address_match_wakeup && dis_ev)
    |=> (kind_q == IWR_K_DISABLE && pending_q);
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not release"); // RULE9
  property p_exit;
    @(posedge mclk) disable iff (!arst_n)
    (accept && comm_exit_bit && !dis_ev) |=> kind_q == IWR_K_EXIT;
  endproperty
  a_exit: assert property (p_exit) else $error("exit bit not taken"); // RULE10
  property p_wakeup;
    @(posedge mclk) disable iff (!arst_n)
    address_match_wakeup |=> $stable(rel_tog_q);
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("release under wakeup"); // RULE11
  property p_scl;
    @(posedge link_clk) disable iff (!link_rst_n)
    byte_wait_req |=> (scl_oe && !scl_o);
  endproperty
  a_scl: assert property (p_scl) else $error("clock line not held"); // RULE12
  property p_once;
    @(posedge mclk) disable iff (!arst_n)
    accept |=> !accept [*2];
  endproperty
  a_once: assert property (p_once) else $error("second release for one wait"); // RULE7
  property p_stop_slave;
    @(posedge mclk) disable iff (!arst_n)
    (!master_mode && stop_request_bit && !start_request_bit && !shift_wr
     && !wait_release_bit && !comm_exit_bit && !dis_ev) |-> !accept;
  endproperty
  a_stop_slave: assert property (p_stop_slave) else $error("slave stop released"); // RULE4
  // once stalled, only a release toggle lets the clock line go
  property p_hold;
    @(posedge link_clk) disable iff (!link_rst_n)
    (link_wait_q && !rel_ev) |=> link_wait_q;
  endproperty
  a_hold: assert property (p_hold) else $error("wait dropped without release"); // RULE12
  // a stray strobe outside a wait must not queue a release for later
  property p_no_wait;
    @(posedge mclk) disable iff (!arst_n)
    !wait_seen |-> !accept;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("release taken outside a wait"); // RULE5
  c_disable: cover property (@(posedge mclk) disable iff (!arst_n) accept && dis_ev);
  c_tx: cover property (@(posedge mclk) disable iff (!arst_n) accept && only_tx);
  c_stop: cover property (@(posedge mclk) disable iff (!arst_n) accept && stop_ok);
  c_resume: cover property (@(posedge link_clk) disable iff (!link_rst_n) resume_pulse);
  c_block: cover property (@(posedge mclk) disable iff (!arst_n)
    wait_seen && address_match_wakeup && wait_release_bit);
endmodule : iwr_wait_release

// *** iwr_link_peer.sv ***
// link-side partner: asks for byte waits and records each resumption
`timescale 1ns/1ns
module iwr_link_peer (
  // link clock and reset
  input wire logic link_clk,
  input wire logic link_rst_n,
  // a toggle of go asks for one wait
  input wire logic go,
  output logic byte_wait_req,
  // resumption from the block
  input wire logic resume_pulse,
  input wire iwr_pkg::iwr_kind_e resume_kind,
  input wire logic [iwr_pkg::IWR_DATA_W-1:0] resume_data,
  output iwr_pkg::iwr_kind_e seen_kind,
  output logic [iwr_pkg::IWR_DATA_W-1:0] seen_data,
  output int unsigned seen_cnt
);
  import iwr_pkg::*;
  logic go_q;
  // one request pulse per toggle, so one wait per release
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      go_q <= 1'b0;
      byte_wait_req <= 1'b0;
      seen_cnt <= 0;
      seen_kind <= IWR_K_NONE;
      seen_data <= 8'h00;
    end else begin
      go_q <= go;
      byte_wait_req <= go ^ go_q;
      if (resume_pulse) begin
        seen_cnt <= seen_cnt + 1;
        seen_kind <= resume_kind;
        seen_data <= resume_data;
      end
    end
  end
endmodule : iwr_link_peer

// *** iwr_wait_release_bench.sv ***
// self-checking bench of the wait-release control
`timescale 1ns/1ns
module iwr_wait_release_bench;
  import iwr_pkg::*;
  logic mclk = 0;
  logic link_clk = 0;
  logic arst_n = 0;
  logic link_rst_n = 0;
  logic [4:0] stb = 5'h00;
  logic [7:0] sdat = 8'h00;
  logic en = 1;
  logic wup = 0;
  logic mst = 1;
  logic go = 0;
  logic wact, racc, rpulse, scl_o, scl_oe, bwr;
  iwr_kind_e rkind, skind;
  logic [7:0] rdata, sdata;
  int unsigned scnt;
  int fails = 0;
  int num_checks = 0;
  // two clocks, phase drifts since 100 and 12 share few edges
  always #50 mclk = ~mclk;
  always #6 link_clk = ~link_clk;
  iwr_wait_release u_iwr_wait_release (.mclk(mclk), .arst_n(arst_n), .shift_wr(stb[0]),
    .serial_shift_reg(sdat), .wait_release_bit(stb[1]), .start_request_bit(stb[2]),
    .stop_request_bit(stb[3]), .comm_exit_bit(stb[4]), .iface_enable_bit(en),
    .address_match_wakeup(wup), .master_mode(mst), .wait_active(wact),
    .release_accepted(racc), .link_clk(link_clk), .link_rst_n(link_rst_n),
    .byte_wait_req(bwr), .resume_pulse(rpulse), .resume_kind(rkind), .resume_data(rdata),
    .scl_o(scl_o), .scl_oe(scl_oe));
  iwr_link_peer u_iwr_link_peer (.link_clk(link_clk), .link_rst_n(link_rst_n), .go(go),
    .byte_wait_req(bwr), .resume_pulse(rpulse), .resume_kind(rkind), .resume_data(rdata),
    .seen_kind(skind), .seen_data(sdata), .seen_cnt(scnt));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  function automatic iwr_kind_e exp_kind(input int k);
    return iwr_kind_e'(k + 1);
  endfunction : exp_kind
  // bounded wait for the synced wait flag
  task automatic wait_for(input logic want);
    int n;
    for (n = 0; n < 50 && wact !== want; n++) @(negedge mclk);
    check(wact, want);
    if (n == 50) finish_test();
  endtask : wait_for
  task automatic enter_wait;
    go = ~go;
    wait_for(1'b1);
    check(scl_oe, 1'b1);
    check(scl_o, 1'b0);
  endtask : enter_wait
  // one action, then if accepted a wait-release that must be refused; never a shift write after wait-release
  task automatic do_release(input int k, input logic [7:0] d);
    logic ok;
    int c0;
    int n;
    ok = !wup && (mst || k < 2 || k > 3);
    c0 = scnt;
    stb = 5'h01 << k;
    sdat = d;
    en = (k != 5);
    #1 check(racc, ok);
    @(negedge mclk);
    stb = ok ? 5'h02 : 5'h00;
    en = 1;
    #1 check(racc, 1'b0);
    @(negedge mclk);
    stb = 5'h00;
    for (n = 0; n < 40 && scnt == c0; n++) @(negedge mclk);
    check(scnt != c0, ok);
    if (ok && n == 40) finish_test();
    check(scl_oe, !ok);
    if (ok) begin
      check(skind, exp_kind(k));
      if (k == 0) check(sdata, d);
      wait_for(1'b0);
    end
  endtask : do_release
  // every kind, then wakeup block, slave mode and random mix
  initial begin
    int k;
    void'($urandom(32'hf22d));
    repeat (3) @(negedge mclk);
    arst_n = 1;
    link_rst_n = 1;
    repeat (2) @(negedge mclk);
    for (k = 0; k < 6; k++) begin
      enter_wait();
      do_release(k, 8'($urandom));
    end
    wup = 1;
    enter_wait();
    do_release(1, 8'h00);
    wup = 0;
    do_release(0, 8'hA5);
    mst = 0;
    enter_wait();
    do_release(2, 8'h00);
    do_release(3, 8'h00);
    do_release(1, 8'h00);
    for (k = 0; k < 8; k++) begin
      mst = 1'($urandom_range(1, 0));
      enter_wait();
      do_release(int'($urandom_range(5, 0)), 8'($urandom));
      if (wact === 1'b1) do_release(1, 8'h00);
    end
    finish_test();
  end
endmodule : iwr_wait_release_bench
